//--- core/serial_port_regs.vh
/*
 * register offsets, field positions, reset values and divider counts
 * for the four-mode serial port; included by the port's design file.
 */
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// register offsets on the plain register port
`define ADDR_SERIAL_CONTROL 4'h0
`define ADDR_SERIAL_DATA 4'h1
`define ADDR_POWER_CONTROL 4'h2
`define ADDR_CLOCK_CONTROL 4'h3
`define ADDR_TIMER1_RELOAD 4'h4
`define ADDR_TIMER2_CONTROL 4'h5
`define ADDR_TIMER2_RELOAD_LOW 4'h6
`define ADDR_TIMER2_RELOAD_HIGH 4'h7

// serial_control_reg fields
`define SC_RX_DONE 0
`define SC_TX_DONE 1
`define SC_RX_NINTH 2
`define SC_TX_NINTH 3
`define SC_RX_ENABLE 4
`define SC_MP_FILTER 5
`define SC_MODE_LO 6
`define SC_MODE_HI 7

// other fields
`define PC_BAUD_DOUBLER 7
`define CC_T1_BYPASS 4
`define T2_RX_SELECT 5
`define T2_TX_SELECT 4
`define T2_EXT_CLOCK 1

// reset values
`define SERIAL_CONTROL_RESET 8'h00
`define POWER_CONTROL_RESET 8'h00
`define CLOCK_CONTROL_RESET 8'h00
`define TIMER2_CONTROL_RESET 8'h00

// modes
`define MODE_SYNC 2'h0
`define MODE_ASYNC8_VAR 2'h1
`define MODE_ASYNC9_FIXED 2'h2
`define MODE_ASYNC9_VAR 2'h3

// divider counts in core clocks
`define SYNC_DIV 4'hC
`define T1_PRESCALE 4'hC
`define T2_PRESCALE 4'h2
`define FIXED_TICK_DIV 2'h2
`define TICKS_PER_BIT 5'h10

`endif

//--- core/serial_port_four_mode.v
/*
 * four-mode serial port: one synchronous shift mode, three asynchronous
 * modes, with a timer 1 auto-reload and a timer 2 baud generator.
 * assumes a single 20 MHz core clock, synchronous active-low reset, and
 * a register master that holds strobes for one cycle each.
 */
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "serial_port_regs.vh"

module serial_port_four_mode (
    input wire REF_CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    input wire [3:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    input wire RXD_I,
    output reg RXD_O,
    output reg RXD_OE_O,
    output reg TXD_O,
    input wire TIMER2_EXT_INPUT_I,
    output wire IRQ_O,
    output wire TIMER2_IRQ_DISABLE_O
);

    localparam ST_IDLE = 2'h0;
    localparam ST_TX = 2'h1;
    localparam ST_RX = 2'h2;

    reg [7:0] serial_control_reg;
    reg [7:0] power_control_reg;
    reg [7:0] clock_control_reg;
    reg [7:0] timer2_control_reg;
    reg [7:0] timer1_reload_byte;
    reg [7:0] timer2_reload_low;
    reg [7:0] timer2_reload_high;
    reg [7:0] rx_holding;
    reg [7:0] timer1_count;
    reg [15:0] timer2_count;
    reg [3:0] t1_pre;
    reg t2_pre;
    reg [3:0] sync_div;
    reg [5:0] fixed_div;
    reg [4:0] t1_div;
    reg rx_meta, rx_sync, t2_meta, t2_sync, t2_last;
    // sync mode engine
    reg [1:0] sync_state;
    reg [7:0] sync_shift;
    reg [3:0] sync_bits;
    // async transmitter
    reg tx_busy;
    reg [10:0] tx_shift;
    reg [3:0] tx_bits;
    reg [3:0] tx_tick;
    // async receiver
    reg rx_busy;
    reg rx_last;
    reg [3:0] rx_tick;
    reg [3:0] rx_bits;
    reg [8:0] rx_shift;
    reg rx_finish;

    wire [1:0] mode = serial_control_reg[`SC_MODE_HI:`SC_MODE_LO];
    wire baud_doubler = power_control_reg[`PC_BAUD_DOUBLER];
    wire timer1_prescale_bypass = clock_control_reg[`CC_T1_BYPASS];
    wire rx_timer2_select = timer2_control_reg[`T2_RX_SELECT];
    wire tx_timer2_select = timer2_control_reg[`T2_TX_SELECT];
    wire timer2_ext_clock_select = timer2_control_reg[`T2_EXT_CLOCK];
    wire tx_done_flag = serial_control_reg[`SC_TX_DONE];
    wire rx_done_flag = serial_control_reg[`SC_RX_DONE];
    wire rx_enable = serial_control_reg[`SC_RX_ENABLE];
    wire multiproc_filter_enable = serial_control_reg[`SC_MP_FILTER];

    // address decode used by the write paths; the read path decodes with its own case
    function sel;
        input [3:0] a;
        input [3:0] target;
        begin
            sel = (a == target);
        end
    endfunction

    wire data_write = CE_I && WR_I && sel(ADDR_I, `ADDR_SERIAL_DATA);
    wire ctrl_write = CE_I && WR_I && sel(ADDR_I, `ADDR_SERIAL_CONTROL);

    // pin synchronisers, first stage read only by the second
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            t2_meta <= 1'b1;
            t2_sync <= 1'b1;
        end else if (CE_I) begin
            rx_meta <= RXD_I;
            rx_sync <= rx_meta;
            t2_meta <= TIMER2_EXT_INPUT_I;
            t2_sync <= t2_meta;
        end
    end

    wire timer1_tick = timer1_prescale_bypass || (t1_pre == `T1_PRESCALE - 4'h1);
    wire t1_ovf = timer1_tick && (timer1_count == 8'hFF);
    wire t2_gen = rx_timer2_select || tx_timer2_select;
    // timer 2 clocked core/2 or falling pin edge
    wire t2_tick = t2_gen && (timer2_ext_clock_select ? (t2_last && !t2_sync) : t2_pre);
    wire t2_ovf = t2_tick && (timer2_count == 16'hFFFF);
    // timer 1 rate divided by 32 or 16
    wire t1_div_wrap = t1_ovf && (baud_doubler || t1_div[0]);
    // fixed rate ticks: 16 ticks per bit, core/64 or core/32
    wire fixed_tick = baud_doubler ? (fixed_div[0]) : (fixed_div[1:0] == 2'h3);
    // sixteen-times tick for each direction
    // timer 2 already divided by sixteen per bit in the engine
    wire var_rx_tick = rx_timer2_select ? t2_ovf : t1_div_wrap;
    wire var_tx_tick = tx_timer2_select ? t2_ovf : t1_div_wrap;
    // mode 3 shares mode 1 rate
    wire rx_tick16 = (mode == `MODE_ASYNC9_FIXED) ? fixed_tick : var_rx_tick;
    wire tx_tick16 = (mode == `MODE_ASYNC9_FIXED) ? fixed_tick : var_tx_tick;
    wire nine_bit = mode[1];

    // timers and dividers
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            timer1_count <= 8'h00;
            timer2_count <= 16'h0000;
            t1_pre <= 4'h0;
            t2_pre <= 1'b0;
            fixed_div <= 6'h00;
            t1_div <= 5'h00;
            t2_last <= 1'b1;
        end else if (CE_I) begin
            t2_last <= t2_sync;
            t2_pre <= ~t2_pre;
            fixed_div <= fixed_div + 6'h01;
            t1_pre <= (t1_pre == `T1_PRESCALE - 4'h1) ? 4'h0 : t1_pre + 4'h1;
            if (timer1_tick) begin
                // auto-reload on rollover
                timer1_count <= t1_ovf ? timer1_reload_byte : timer1_count + 8'h01;
            end
            if (!t2_gen) begin
                // parked on its reload so the first bit is not stretched by a long count
                timer2_count <= {timer2_reload_high, timer2_reload_low};
            end else if (t2_tick) begin
                timer2_count <= t2_ovf ? {timer2_reload_high, timer2_reload_low} :
                    timer2_count + 16'h0001;
            end
            if (t1_ovf) begin
                t1_div <= t1_div + 5'h01;
            end
        end
    end

    wire rx_start_edge = rx_last && !rx_sync;
    wire [3:0] rx_frame_bits = nine_bit ? 4'hA : 4'h9;

    // register file, engines and flags
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            serial_control_reg <= `SERIAL_CONTROL_RESET;
            power_control_reg <= `POWER_CONTROL_RESET;
            clock_control_reg <= `CLOCK_CONTROL_RESET;
            timer2_control_reg <= `TIMER2_CONTROL_RESET;
            timer1_reload_byte <= 8'h00;
            timer2_reload_low <= 8'h00;
            timer2_reload_high <= 8'h00;
            rx_holding <= 8'h00;
            RDATA_O <= 8'h00;
            sync_state <= ST_IDLE;
            sync_shift <= 8'h00;
            sync_bits <= 4'h0;
            sync_div <= 4'h0;
            RXD_O <= 1'b1;
            RXD_OE_O <= 1'b0;
            TXD_O <= 1'b1;
            tx_busy <= 1'b0;
            tx_shift <= 11'h7FF;
            tx_bits <= 4'h0;
            tx_tick <= 4'h0;
            rx_busy <= 1'b0;
            rx_last <= 1'b1;
            rx_tick <= 4'h0;
            rx_bits <= 4'h0;
            rx_shift <= 9'h000;
            rx_finish <= 1'b0;
        end else if (CE_I) begin
            rx_last <= rx_sync;
            // register writes; hardware sets below win over a clear
            // only a write clears flags
            if (ctrl_write) begin
                serial_control_reg <= WDATA_I;
            end
            if (WR_I && sel(ADDR_I, `ADDR_POWER_CONTROL)) begin
                power_control_reg <= WDATA_I;
            end
            if (WR_I && sel(ADDR_I, `ADDR_CLOCK_CONTROL)) begin
                clock_control_reg <= WDATA_I;
            end
            if (WR_I && sel(ADDR_I, `ADDR_TIMER1_RELOAD)) begin
                timer1_reload_byte <= WDATA_I;
            end
            if (WR_I && sel(ADDR_I, `ADDR_TIMER2_CONTROL)) begin
                timer2_control_reg <= WDATA_I;
            end
            if (WR_I && sel(ADDR_I, `ADDR_TIMER2_RELOAD_LOW)) begin
                timer2_reload_low <= WDATA_I;
            end
            if (WR_I && sel(ADDR_I, `ADDR_TIMER2_RELOAD_HIGH)) begin
                timer2_reload_high <= WDATA_I;
            end
            // read path: data location returns receive holding
            if (RD_I) begin
                case (ADDR_I)
                    `ADDR_SERIAL_CONTROL: RDATA_O <= serial_control_reg;
                    `ADDR_SERIAL_DATA: RDATA_O <= rx_holding;
                    `ADDR_POWER_CONTROL: RDATA_O <= power_control_reg;
                    `ADDR_CLOCK_CONTROL: RDATA_O <= clock_control_reg;
                    `ADDR_TIMER1_RELOAD: RDATA_O <= timer1_reload_byte;
                    `ADDR_TIMER2_CONTROL: RDATA_O <= timer2_control_reg;
                    `ADDR_TIMER2_RELOAD_LOW: RDATA_O <= timer2_reload_low;
                    `ADDR_TIMER2_RELOAD_HIGH: RDATA_O <= timer2_reload_high;
                    default: RDATA_O <= 8'h00;
                endcase
            end

            if (mode == `MODE_SYNC) begin
                tx_busy <= 1'b0;
                rx_busy <= 1'b0;
                // master, shift clock core/12 on the transmit pin
                case (sync_state)
                    ST_IDLE: begin
                        TXD_O <= 1'b1;
                        RXD_OE_O <= 1'b0;
                        sync_div <= 4'h0;
                        sync_bits <= 4'h0;
                        if (data_write) begin
                            sync_shift <= WDATA_I;
                            RXD_O <= WDATA_I[0];
                            RXD_OE_O <= 1'b1;
                            sync_state <= ST_TX;
                        end else if (rx_enable && !rx_done_flag && !ctrl_write) begin
                            // reception begins when enabled, flag clear
                            sync_state <= ST_RX;
                        end
                    end
                    ST_TX, ST_RX: begin
                        sync_div <= (sync_div == `SYNC_DIV - 4'h1) ? 4'h0 : sync_div + 4'h1;
                        TXD_O <= (sync_div >= 4'h6);
                        if (sync_div == 4'h6 && sync_state == ST_RX) begin
                            // sample on rising shift clock, lsb first
                            sync_shift <= {rx_sync, sync_shift[7:1]};
                        end
                        if (sync_div == `SYNC_DIV - 4'h1) begin
                            sync_bits <= sync_bits + 4'h1;
                            if (sync_state == ST_TX) begin
                                sync_shift <= {1'b0, sync_shift[7:1]};
                                RXD_O <= sync_shift[1];
                            end
                            if (sync_bits == 4'h7) begin
                                sync_state <= (sync_state == ST_TX) ? ST_IDLE : 2'h3;
                                RXD_OE_O <= 1'b0;
                                TXD_O <= 1'b1;
                                if (sync_state == ST_TX) begin
                                    // done at end of eighth bit
                                    serial_control_reg[`SC_TX_DONE] <= 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        // one cycle after the eighth bit, then halt
                        // byte passes into the holding register
                        rx_holding <= sync_shift;
                        serial_control_reg[`SC_RX_DONE] <= 1'b1;
                        sync_state <= ST_IDLE;
                    end
                endcase
            end else begin
                sync_state <= ST_IDLE;
                RXD_OE_O <= 1'b0;
                if (data_write && !tx_busy) begin
                    // start, data lsb first, ninth, stop
                    tx_shift <= {1'b1, nine_bit ? serial_control_reg[`SC_TX_NINTH] : 1'b1,
                        WDATA_I, 1'b0};
                    tx_busy <= 1'b1;
                    tx_bits <= 4'h0;
                    tx_tick <= 4'h0;
                end else if (tx_busy && tx_tick16) begin
                    tx_tick <= tx_tick + 4'h1;
                    if (tx_tick == 4'hF) begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        tx_bits <= tx_bits + 4'h1;
                        // flag set as the stop bit begins
                        if (tx_bits == rx_frame_bits - 4'h1) begin
                            serial_control_reg[`SC_TX_DONE] <= 1'b1;
                        end
                        if (tx_bits == rx_frame_bits) begin
                            tx_busy <= 1'b0;
                        end
                    end
                end
                TXD_O <= tx_busy ? tx_shift[0] : 1'b1;

                rx_finish <= 1'b0;
                if (!rx_busy) begin
                    if (rx_enable && rx_start_edge) begin
                        rx_busy <= 1'b1;
                        rx_tick <= 4'h0;
                        rx_bits <= 4'h0;
                    end
                end else if (rx_tick16) begin
                    rx_tick <= rx_tick + 4'h1;
                    if (rx_tick == 4'h7) begin
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == 4'h0) begin
                            // false start rejected
                            rx_busy <= rx_sync ? 1'b0 : 1'b1;
                        end else if (rx_bits == rx_frame_bits) begin
                            rx_busy <= 1'b0;
                            rx_finish <= 1'b1;
                            if (!nine_bit) begin
                                // stop bit lands in the ninth position
                                rx_shift <= {rx_sync, rx_shift[8:1]};
                            end
                        end else begin
                            rx_shift <= {rx_sync, rx_shift[8:1]};
                        end
                    end
                end
                // store only if flag clear and filter passes
                if (rx_finish && !rx_done_flag && (!multiproc_filter_enable || rx_shift[8])) begin
                    // holding register frees shifter for next frame
                    rx_holding <= rx_shift[7:0];
                    serial_control_reg[`SC_RX_NINTH] <= rx_shift[8];
                    serial_control_reg[`SC_RX_DONE] <= 1'b1;
                end
            end
        end
    end

    assign IRQ_O = tx_done_flag || rx_done_flag;
    // timer 2 interrupts off while it makes baud
    assign TIMER2_IRQ_DISABLE_O = t2_gen;

endmodule // serial_port_four_mode

//--- testbench/serial_port_four_mode_monitor.sv
/* assertion checker on the serial port's top-level ports.
   assumes it is bound to the design and sees its one core clock. */
`timescale 1ns/1ps
module serial_port_monitor (
    input wire REF_CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    input wire [3:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] RDATA_O,
    input wire RXD_O,
    input wire RXD_OE_O,
    input wire TXD_O,
    input wire IRQ_O,
    input wire TIMER2_IRQ_DISABLE_O
);
    reg [1:0] mode;
    reg [9:0] idle_cnt;
    wire wr_ctl = CE_I && WR_I && ADDR_I == 4'h0;
    wire wr_dat = CE_I && WR_I && ADDR_I == 4'h1;
    wire wr_t2 = CE_I && WR_I && ADDR_I == 4'h5;
    default clocking mon_cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // mode mirror; line idle longer than a whole frame means tx is free
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            mode <= 2'h0;
            idle_cnt <= 10'h000;
        end else begin
            if (wr_ctl)
                mode <= WDATA_I[7:6];
            if (!TXD_O)
                idle_cnt <= 10'h000;
            else if (idle_cnt != 10'h3FF)
                idle_cnt <= idle_cnt + 10'h001;
        end
    end
    read_hold_a: assert property ($changed(RDATA_O) |-> $past(RD_I && CE_I))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (RD_I && CE_I && ADDR_I[3] |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    t2_force_on_a: assert property (wr_t2 && WDATA_I[5:4] != 2'h0 |=> TIMER2_IRQ_DISABLE_O)
        else $error("timer 2 interrupts not disabled");
    t2_force_off_a: assert property (wr_t2 && WDATA_I[5:4] == 2'h0 |=> !TIMER2_IRQ_DISABLE_O)
        else $error("timer 2 interrupts still disabled");
    flag_hold_a: assert property (IRQ_O && !wr_ctl |=> IRQ_O)
        else $error("done flag dropped without a software write");
    sync_clock_a: assert property ($fell(TXD_O) && RXD_OE_O |-> (!TXD_O)[*6] ##1 TXD_O)
        else $error("shift clock phase not six cycles");
    sync_start_a: assert property (
        wr_dat && mode == 2'h0 && !RXD_OE_O |=> RXD_OE_O && RXD_O == $past(WDATA_I[0]))
        else $error("sync shift did not start with bit 0");
    sync_length_a: assert property ($rose(RXD_OE_O) |-> ##90 RXD_OE_O ##[1:8] !RXD_OE_O)
        else $error("sync drive not eight bit times");
    async_start_a: assert property (
        wr_dat && mode == 2'h2 && idle_cnt > 10'h2C0 |-> ##[1:80] $fell(TXD_O) ##1 (!TXD_O)[*8])
        else $error("async write did not start a frame");
endmodule // serial_port_monitor

//--- testbench/far_uart_model.sv
/* far-side serial partner: sends frames on the receive line and decodes
   frames from the transmit line. assumes bit length set by the bench. */
`timescale 1ns/1ps
module far_uart_model (
    input wire clk_i,
    input wire listen_i,
    input wire [7:0] bit_len_i,
    input wire txd_i,
    output reg line_o = 1'b1,
    output reg [8:0] got_o = 9'h000,
    output reg got_valid_o = 1'b0
);
    integer k;
    // start, lsb first, ninth or stop from d[8], stop
    task send(input [8:0] d);
        reg [10:0] frame;
        integer j;
        begin
            frame = {1'b1, d, 1'b0};
            for (j = 0; j < 11; j = j + 1) begin
                line_o <= frame[j];
                repeat (bit_len_i) @(posedge clk_i);
            end
        end
    endtask
    // decode nine bits mid-bit after each start edge
    always begin
        @(negedge txd_i);
        if (listen_i) begin
            repeat (bit_len_i / 2) @(posedge clk_i);
            for (k = 0; k < 9; k = k + 1) begin
                repeat (bit_len_i) @(posedge clk_i);
                got_o[k] = txd_i;
            end
            repeat (bit_len_i / 2) @(posedge clk_i);
            got_valid_o <= 1'b1;
            @(posedge clk_i);
            got_valid_o <= 1'b0;
        end
    end
endmodule // far_uart_model

//--- testbench/serial_port_four_mode_tb_top.sv
/* bench top for the four-mode serial port: register master, partner,
   expectation queues and report. assumes design and partner compiled. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module serial_port_four_mode_tb_top;
    reg clk, rst_n, wr, rd, t2_ext, listen, rd_seen, txd_d;
    reg [3:0] addr;
    reg [7:0] wdata, d, bit_len, e_rd;
    reg [8:0] e_ln;
    reg e_bit;
    wire [7:0] rdata;
    wire [8:0] got;
    wire rxd_out, rxd_oe, txd, irq, t2_dis, far_line, got_valid;
    wire rxd = rxd_oe ? rxd_out : far_line;
    integer seed, err_count, total_checks, i;
    integer cycles = 0;
    logic [7:0] rd_q[$];
    logic [8:0] link_q[$];
    logic sync_q[$];
    serial_port_four_mode u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .RXD_I(rxd), .RXD_O(rxd_out), .RXD_OE_O(rxd_oe), .TXD_O(txd),
        .TIMER2_EXT_INPUT_I(t2_ext), .IRQ_O(irq), .TIMER2_IRQ_DISABLE_O(t2_dis));
    far_uart_model u_far (.clk_i(clk), .listen_i(listen), .bit_len_i(bit_len),
        .txd_i(txd), .line_o(far_line), .got_o(got), .got_valid_o(got_valid));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task end_of_test;
        begin
            // results still owed by the design count as mismatches
            if (rd_q.size() + link_q.size() + sync_q.size() != 0)
                err_count++;
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wr_reg(input [3:0] a, input [7:0] v);
        begin
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd_reg(input [3:0] a, input [7:0] e);
        begin
            rd_q.push_back(e);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(posedge clk);
        end
    endtask
    // async send; the wait lets the line idle past a frame first
    task tx_frame(input [7:0] ctl, input [7:0] len);
        begin
            wr_reg(4'h0, ctl);
            bit_len = len;
            listen = 1'b1;
            repeat (720) @(posedge clk);
            d = 8'($random(seed));
            link_q.push_back({ctl[7] ? ctl[3] : 1'b1, d});
            wr_reg(4'h1, d);
            repeat (12 * len) @(posedge clk);
            rd_reg(4'h0, ctl | 8'h02);
        end
    endtask
    task rx_frame(input [7:0] len, input [8:0] v);
        begin
            bit_len = len;
            u_far.send(v);
            repeat (4) @(posedge clk);
        end
    endtask
    // watcher: each result that appears is matched with the oldest note
    always @(posedge clk) begin
        rd_seen <= rd && rst_n;
        txd_d <= txd;
        cycles = cycles + 1;
        // slow external timer 2 input, one edge every four cycles
        t2_ext <= cycles[2];
        if (rd_seen) begin
            e_rd = rd_q.pop_front();
            `CHK("read data", e_rd, rdata)
        end
        if (got_valid) begin
            e_ln = link_q.pop_front();
            `CHK("link frame", e_ln, got)
        end
        if (rxd_oe && txd && !txd_d) begin
            e_bit = sync_q.pop_front();
            `CHK("sync bit", e_bit, rxd_out)
        end
        if (cycles == 20000) begin
            err_count++;
            end_of_test;
        end
    end
    initial begin
        seed = 58766;
        err_count = 0;
        total_checks = 0;
        {rst_n, wr, rd, addr, wdata, listen} = 16'h0000;
        bit_len = 8'h10;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and two unmapped places
        for (i = 0; i < 10; i = i + 1)
            rd_reg(i[3:0], 8'h00);
        // sync shift out then sync receive of the idle-high line
        d = 8'($random(seed));
        for (i = 0; i < 8; i = i + 1)
            sync_q.push_back(d[i]);
        wr_reg(4'h1, d);
        repeat (120) @(posedge clk);
        rd_reg(4'h0, 8'h02);
        `CHK("irq", 1'b1, irq)
        wr_reg(4'h0, 8'h10);
        `CHK("irq", 1'b0, irq)
        repeat (150) @(posedge clk);
        rd_reg(4'h1, 8'hFF);
        rd_reg(4'h0, 8'h11);
        // nine-bit fixed rate at both doubler settings
        for (i = 0; i < 2; i = i + 1) begin
            wr_reg(4'h2, i ? 8'h80 : 8'h00);
            tx_frame(i ? 8'h80 : 8'h88, i ? 8'h20 : 8'h40);
        end
        // eight-bit on timer 1 at one tick a cycle
        wr_reg(4'h3, 8'h10);
        wr_reg(4'h4, 8'hFF);
        wr_reg(4'h2, 8'h00);
        tx_frame(8'h40, 8'h20);
        wr_reg(4'h2, 8'h80);
        wr_reg(4'h0, 8'h50);
        d = 8'($random(seed));
        rx_frame(8'h10, {1'b1, d});
        rx_frame(8'h10, {1'b1, ~d});
        rd_reg(4'h1, d);
        rd_reg(4'h0, 8'h55);
        wr_reg(4'h0, 8'h70);
        rx_frame(8'h10, {1'b0, ~d});
        rd_reg(4'h0, 8'h70);
        // nine-bit on timer 2: data frame ignored, address frame taken
        wr_reg(4'h6, 8'hFF);
        wr_reg(4'h7, 8'hFF);
        wr_reg(4'h5, 8'h30);
        `CHK("t2 irq off", 1'b1, t2_dis)
        wr_reg(4'h0, 8'hF0);
        rx_frame(8'h20, {1'b0, d});
        `CHK("irq", 1'b0, irq)
        rx_frame(8'h20, {1'b1, ~d});
        rd_reg(4'h1, ~d);
        rd_reg(4'h0, 8'hF5);
        tx_frame(8'hC8, 8'h20);
        // external pin clocks timer 2: one overflow per falling edge
        wr_reg(4'h5, 8'h32);
        tx_frame(8'hC8, 8'h80);
        wr_reg(4'h5, 8'h00);
        `CHK("t2 irq off", 1'b0, t2_dis)
        end_of_test;
    end
endmodule // serial_port_four_mode_tb_top
bind serial_port_four_mode serial_port_monitor u_mon (.REF_CLK_I(REF_CLK_I),
    .RST_N_I(RST_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .RXD_O(RXD_O), .RXD_OE_O(RXD_OE_O), .TXD_O(TXD_O),
    .IRQ_O(IRQ_O), .TIMER2_IRQ_DISABLE_O(TIMER2_IRQ_DISABLE_O));
